// ---- core/ipb_pkg.sv ----
// Shared constants and types for the interleaved PCM bus slot control.
// Assumes one device clock; the bus pins are sampled from outside it.
package ipb_pkg;

  // Configuration register
  localparam logic [7:0] IPB_CFG_ADDR = 8'h1C;
  localparam logic [7:0] IPB_CFG_RESET = 8'h00;
  localparam logic [7:0] IPB_CFG_WMASK = 8'h7F;
  localparam logic [7:0] IPB_RD_UNMAPPED = 8'h00;

  // Bus framing: 32 channels of 8 bits per stream per frame
  localparam int IPB_CNT_W = 11;
  localparam logic [11:0] IPB_BITS_PER_STREAM = 12'h100;
  localparam logic [2:0] IPB_FIRST_BIT = 3'h0;
  localparam logic [2:0] IPB_LAST_BIT = 3'h7;
  localparam logic [IPB_CNT_W-1:0] IPB_CNT_RESET = 11'h000;
  localparam logic [7:0] IPB_IDLE_BYTE = 8'hFF;

  // Pin sampling
  localparam int IPB_PIN_N = 4;
  localparam int IPB_PIN_SYS = 0;
  localparam int IPB_PIN_TXC = 1;
  localparam int IPB_PIN_FS = 2;
  localparam int IPB_PIN_DIN = 3;
  localparam logic [IPB_PIN_N-1:0] IPB_PIN_RESET = 4'h0;

  // Receive buffer
  localparam int IPB_BYTE_W = 8;
  localparam int IPB_FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    IPB_SPD_2M = 2'b00,
    IPB_SPD_4M = 2'b01,
    IPB_SPD_8M = 2'b10,
    IPB_SPD_16M = 2'b11
  } ipb_speed_t;

  typedef struct packed {
    logic rsvd;
    logic tx_clk_src;
    ipb_speed_t speed;
    logic ilv_en;
    logic [2:0] pos;
  } ipb_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ipb_reg_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } ipb_pin_t;

endpackage

// ---- core/ipb_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; storage lives in flip-flops.
`timescale 1ns/1ps
module ipb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = count_r != FULL_CNT;
  assign out_valid = count_r != '0;
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ---- core/ipb_slot_ctrl.sv ----
// Slot control for one transceiver on a shared, channel-interleaved PCM bus.
// Assumes bus pins arrive asynchronously and are much slower than clk.
//
// Notes on behaviour
// - Speed field picks 2.048, 4.096, 8.192 or 16.384 MHz; 1, 2, 4, 8 streams.
// - Position field bits 2..0 places us in the slot equal to its value.
// - Interleave enable bit 3 turns interleaved operation on or off.
// - Bit 6 picks transmit clock: zero the tx clock pin, one system clock.
// - Streams are combined channel by channel, never bit or frame wise.
// - Own configuration register at 1C sets speed and position independently.
`timescale 1ns/1ps
module ipb_slot_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire ipb_pkg::ipb_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic system_clock_pin,
  input wire logic tx_clock_pin,
  input wire logic bus_frame_sync,
  input wire logic bus_data_in,
  output ipb_pkg::ipb_pin_t bus_data_out,
  output ipb_pkg::ipb_pin_t tx_frame_sync_pin,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_drop
);
  import ipb_pkg::*;

  ipb_cfg_t cfg_r;
  logic [7:0] rdata_r;
  logic [IPB_PIN_N-1:0] pin_s1_r;
  logic [IPB_PIN_N-1:0] pin_s2_r;
  logic sys_d_r;
  logic tx_lvl_d_r;
  logic sys_rise;
  logic sys_fall;
  logic tx_lvl;
  logic tx_rise;
  logic frame_sync;
  logic [1:0] shift;
  logic [IPB_CNT_W-1:0] rx_cnt_r;
  logic [IPB_CNT_W-1:0] tx_cnt_r;
  logic [IPB_CNT_W-1:0] tx_cnt_nxt;
  logic [7:0] tx_sr_r;
  logic [7:0] tx_hold_r;
  logic tx_hold_vld_r;
  logic tx_load;
  logic [7:0] rx_sr_r;
  logic rx_push;
  logic [7:0] rx_push_data;
  logic fifo_in_ready;
  logic rx_drop_r;
  logic rx_own;
  logic tx_own;
  logic [11:0] frame_last;

  // Wrap point of the bit counter for 2^sh streams
  function automatic logic [IPB_CNT_W-1:0] cnt_next(input logic [IPB_CNT_W-1:0] c,
                                                   input logic [1:0] sh);
    logic [11:0] last;
    last = (IPB_BITS_PER_STREAM << sh) - 12'h001;
    return ({1'b0, c} >= last) ? IPB_CNT_RESET : c + 11'h001;
  endfunction

  // Slot is the counter field just above the bit index
  function automatic logic owns(input logic [IPB_CNT_W-1:0] c, input ipb_cfg_t cf,
                                input logic [1:0] sh);
    logic [2:0] mask;
    mask = 3'((4'h1 << sh) - 4'h1);
    return !cf.ilv_en || ((c[5:3] & mask) == cf.pos);
  endfunction

  // Configuration register; reserved bit is never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= ipb_cfg_t'(IPB_CFG_RESET);
    end else if (reg_req.wr && reg_req.addr == IPB_CFG_ADDR) begin
      cfg_r <= ipb_cfg_t'(reg_req.wdata & IPB_CFG_WMASK);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= IPB_RD_UNMAPPED;
    end else if (reg_req.rd) begin
      if (reg_req.addr == IPB_CFG_ADDR) begin
        rdata_r <= cfg_r;
      end else begin
        rdata_r <= IPB_RD_UNMAPPED;
      end
    end
  end

  assign reg_rdata = rdata_r;

  // Two-stage sampling of every bus pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= IPB_PIN_RESET;
      pin_s2_r <= IPB_PIN_RESET;
    end else begin
      pin_s1_r <= {bus_data_in, bus_frame_sync, tx_clock_pin, system_clock_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Changing the clock source may create one spurious edge; reframe after it
  assign tx_lvl = cfg_r.tx_clk_src ? pin_s2_r[IPB_PIN_SYS] : pin_s2_r[IPB_PIN_TXC];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_d_r <= 1'b0;
      tx_lvl_d_r <= 1'b0;
    end else begin
      sys_d_r <= pin_s2_r[IPB_PIN_SYS];
      tx_lvl_d_r <= tx_lvl;
    end
  end

  assign sys_rise = pin_s2_r[IPB_PIN_SYS] && !sys_d_r;
  assign sys_fall = !pin_s2_r[IPB_PIN_SYS] && sys_d_r;
  assign tx_rise = tx_lvl && !tx_lvl_d_r;
  assign frame_sync = pin_s2_r[IPB_PIN_FS];
  // Non-interleaved operation behaves as a single stream
  assign shift = cfg_r.ilv_en ? cfg_r.speed : IPB_SPD_2M;

  // Receive side: count on rising system clock, sample on falling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_cnt_r <= IPB_CNT_RESET;
    end else if (sys_rise) begin
      rx_cnt_r <= frame_sync ? IPB_CNT_RESET : cnt_next(rx_cnt_r, shift);
    end
  end

  assign rx_own = owns(rx_cnt_r, cfg_r, shift);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sr_r <= IPB_IDLE_BYTE;
    end else if (sys_fall && rx_own) begin
      rx_sr_r <= {rx_sr_r[6:0], pin_s2_r[IPB_PIN_DIN]};
    end
  end

  // Whole channel byte handed on at its last bit
  assign rx_push = sys_fall && rx_own && rx_cnt_r[2:0] == IPB_LAST_BIT;
  assign rx_push_data = {rx_sr_r[6:0], pin_s2_r[IPB_PIN_DIN]};

  // The bus cannot wait, so a full buffer loses the byte and says so
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_drop_r <= 1'b0;
    end else begin
      rx_drop_r <= rx_push && !fifo_in_ready;
    end
  end

  assign rx_drop = rx_drop_r;

  ipb_fifo #(
    .WIDTH(IPB_BYTE_W),
    .DEPTH(IPB_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_byte)
  );

  // Transmit side: counter and shifter advance on the chosen clock
  assign tx_cnt_nxt = frame_sync ? IPB_CNT_RESET : cnt_next(tx_cnt_r, shift);
  assign tx_own = owns(tx_cnt_r, cfg_r, shift);
  assign tx_load = tx_rise && owns(tx_cnt_nxt, cfg_r, shift) &&
                   tx_cnt_nxt[2:0] == IPB_FIRST_BIT;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_cnt_r <= IPB_CNT_RESET;
    end else if (tx_rise) begin
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sr_r <= IPB_IDLE_BYTE;
    end else if (tx_load) begin
      tx_sr_r <= tx_hold_vld_r ? tx_hold_r : IPB_IDLE_BYTE;
    end else if (tx_rise && owns(tx_cnt_nxt, cfg_r, shift)) begin
      tx_sr_r <= {tx_sr_r[6:0], 1'b1};
    end
  end

  // One byte waits per channel period; idle ones go out when none waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_hold_r <= IPB_IDLE_BYTE;
      tx_hold_vld_r <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      tx_hold_r <= tx_byte;
      tx_hold_vld_r <= 1'b1;
    end else if (tx_load) begin
      tx_hold_vld_r <= 1'b0;
    end
  end

  assign tx_ready = !tx_hold_vld_r;
  assign bus_data_out.out = tx_sr_r[7];
  assign bus_data_out.oe = tx_own;
  // Sync pin is only an output while interleaving
  assign tx_frame_sync_pin.out = cfg_r.ilv_en && tx_cnt_r == IPB_CNT_RESET;
  assign tx_frame_sync_pin.oe = cfg_r.ilv_en;

  cfg_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == IPB_CFG_ADDR) |=> $stable(cfg_r))
    else $error("config changed without a write");

  cfg_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_req.rd && reg_req.addr == IPB_CFG_ADDR |=> reg_rdata == $past(cfg_r) && !reg_rdata[7])
    else $error("config readback wrong");

  speed_wrap_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r.ilv_en && cfg_r.speed == IPB_SPD_16M |-> shift == 2'b11)
    else $error("speed field not applied");

  ilv_off_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_r.ilv_en |-> bus_data_out.oe && !tx_frame_sync_pin.oe)
    else $error("non-interleaved drive wrong");

  slot_match_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r.ilv_en && cfg_r.speed == IPB_SPD_16M && bus_data_out.oe |-> tx_cnt_r[5:3] == cfg_r.pos)
    else $error("drive outside own slot");

  clk_src_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r.tx_clk_src && $stable(cfg_r) |-> tx_rise == sys_rise)
    else $error("tx clock not from system clock");

  byte_start_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r.ilv_en && $stable(cfg_r) && $rose(bus_data_out.oe) |-> tx_cnt_r[2:0] == IPB_FIRST_BIT)
    else $error("slot entered mid byte");

  rx_slot_a: assert property (@(posedge clk) disable iff (rst)
    rx_push |-> rx_own && rx_cnt_r[2:0] == IPB_LAST_BIT ##1 rx_drop == !$past(fifo_in_ready))
    else $error("receive push outside slot");

  // Last bit of a frame for the stream count in use
  assign frame_last = (IPB_BITS_PER_STREAM << shift) - 12'h001;

  frame_wrap_a: assert property (@(posedge clk) disable iff (rst)
    sys_rise && {1'b0, rx_cnt_r} == frame_last |=> rx_cnt_r == IPB_CNT_RESET)
    else $error("frame did not wrap at its last bit");

  cnt_step_a: assert property (@(posedge clk) disable iff (rst)
    sys_rise && !frame_sync && {1'b0, rx_cnt_r} < frame_last |=>
      rx_cnt_r == $past(rx_cnt_r) + 11'h001)
    else $error("bit counter skipped a bit");

  tx_load_a: assert property (@(posedge clk) disable iff (rst)
    tx_load && !reg_req.wr |=> bus_data_out.oe && tx_cnt_r[2:0] == IPB_FIRST_BIT)
    else $error("byte loaded outside own slot start");

  sync_out_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r.ilv_en && tx_rise && frame_sync && !reg_req.wr |=> tx_frame_sync_pin.out)
    else $error("transmit sync not driven at frame start");

  tx_accept_a: assert property (@(posedge clk) disable iff (rst)
    tx_valid && tx_ready |=> !tx_ready && tx_hold_r == $past(tx_byte))
    else $error("transmit byte not held");

  rx_quiet_a: assert property (@(posedge clk) disable iff (rst)
    sys_fall && !rx_own |=> $stable(rx_sr_r))
    else $error("receive sampled outside own slot");

  rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  unmapped_rd_a: assert property (@(posedge clk) disable iff (rst)
    reg_req.rd && reg_req.addr != IPB_CFG_ADDR |=> reg_rdata == IPB_RD_UNMAPPED)
    else $error("unmapped read not zero");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_r.rsvd)
    else $error("reserved bit stored");

  drop_pulse_a: assert property (@(posedge clk) disable iff (rst)
    rx_drop |=> !rx_drop)
    else $error("drop flag longer than one cycle");

  sync_oe_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r.ilv_en |-> tx_frame_sync_pin.oe)
    else $error("sync pin not driven while interleaving");

  pin_clk_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_r.tx_clk_src && $stable(cfg_r) && $stable(pin_s2_r[IPB_PIN_TXC]) |-> !tx_rise)
    else $error("tx edge without tx clock pin edge");

  idle_fill_a: assert property (@(posedge clk) disable iff (rst)
    tx_load && !tx_hold_vld_r |=> tx_sr_r == IPB_IDLE_BYTE)
    else $error("idle byte not sent");

endmodule

// ---- testbench/ipb_backplane_model.sv ----
// Behavioural backplane: bus clocks, frame sync, receive data and a tap on our drive.
// Assumes run is raised only while the bus clock stands low.
`timescale 1ns/1ps
module ipb_backplane_model (
  input wire logic run,
  input wire logic tx_clock_pin_en,
  input wire logic drv_oe,
  input wire logic drv_out,
  input wire logic sync_out,
  output logic sck,
  output logic tck,
  output logic fs,
  output logic din,
  output logic done,
  output logic [7:0] drv_cnt,
  output logic [7:0] first_cnt,
  output logic [7:0] cap,
  output logic [7:0] sync_cnt
);
  logic [7:0] cnt;
  logic [7:0] pat;
  initial begin
    sck = 1'b0;
    fs = 1'b0;
    din = 1'b0;
    done = 1'b0;
    cnt = 8'h00;
  end
  // Tx pin clock may stand still to prove the source select
  assign tck = sck & tx_clock_pin_en;
  always @(posedge run) begin
    drv_cnt = 8'h00;
    first_cnt = 8'hFF;
    cap = 8'h00;
    sync_cnt = 8'h00;
    done = 1'b0;
    fs = 1'b1;
  end
  // Clock stands still between frames; 125 ns bit period
  // Quarter-ns phase keeps every pin change off the device clock edges
  initial begin
    #0.25;
    forever begin
      #62.5;
      if (run && !done) begin
        sck = ~sck;
        if (sck) begin
          cnt = fs ? 8'h00 : cnt + 8'h01;
          // Odd slots carry a different byte from even ones, as other positions would
          pat = 8'hA5 ^ {7'h00, cnt[3]};
          din = pat[3'h7 - cnt[2:0]];
        end else begin
          // Sync is ours alone; the tx sync pin the device drives is only counted here
          fs = 1'b0;
          if (sync_out)
            sync_cnt = sync_cnt + 8'h01;
          if (drv_oe && cnt < 8'h40) begin
            if (first_cnt == 8'hFF)
              first_cnt = cnt;
            if (drv_cnt < 8'h08)
              cap = {cap[6:0], drv_out};
            drv_cnt = drv_cnt + 8'h01;
          end
          done = (cnt == 8'h80);
          if (done)
            din = ~din;
        end
      end
    end
  end
endmodule

// ---- testbench/tb_ipb_slot_ctrl.sv ----
// Self-checking bench for the interleaved bus slot control.
// Assumes the backplane model supplies every bus pin.
`timescale 1ns/1ps
module tb_ipb_slot_ctrl;
  import ipb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ipb_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata, rx_byte, rd, drv_cnt, first_cnt, cap, sync_cnt;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] drops = 8'h00;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic run = 1'b0;
  logic tx_clock_pin_en = 1'b0;
  logic tx_ready, rx_valid, rx_drop, sck, tck, fs, din, done;
  ipb_pin_t bus_data_out, tx_frame_sync_pin;
  logic [31:0] e;
  // {config, tx pin clock on, driven bits in 64, first driven bit}; bit 7 kept zero
  logic [31:0] runs [7] = '{32'h5901_2008, 32'h1900_00FF, 32'h1901_2008, 32'h6A01_1010,
                            32'h7F01_0838, 32'h4801_4000, 32'h0001_4000};
  int error_cnt = 0;
  int total_checks = 0;

  always #4 clk = ~clk;
  always @(posedge clk)
    if (rx_drop === 1'b1)
      drops <= drops + 8'h01;

  ipb_slot_ctrl i_ipb_slot_ctrl (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .system_clock_pin(sck), .tx_clock_pin(tck), .bus_frame_sync(fs), .bus_data_in(din),
    .bus_data_out(bus_data_out), .tx_frame_sync_pin(tx_frame_sync_pin), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_drop(rx_drop));
  ipb_backplane_model i_ipb_backplane_model (.run(run), .tx_clock_pin_en(tx_clock_pin_en),
    .drv_oe(bus_data_out.oe), .drv_out(bus_data_out.out), .sync_out(tx_frame_sync_pin.out),
    .sck(sck), .tck(tck), .fs(fs), .din(din), .done(done), .drv_cnt(drv_cnt),
    .first_cnt(first_cnt), .cap(cap), .sync_cnt(sync_cnt));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) reg_req <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) reg_req <= '0;
    #1 rd = reg_rdata;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_rd(IPB_CFG_ADDR);
    chk("reset cfg", IPB_CFG_RESET, rd);
    reg_wr(IPB_CFG_ADDR, 8'h7F);
    reg_wr(8'h1B, 8'h55);
    reg_rd(IPB_CFG_ADDR);
    chk("cfg", 8'h7F, rd);
    reg_rd(8'h1B);
    chk("unmapped", 8'h00, rd);
    for (int s = 0; s < 4; s++) begin
      reg_wr(IPB_CFG_ADDR, {2'b00, s[1:0], 4'h9});
      reg_rd(IPB_CFG_ADDR);
      chk("speed", {2'b00, s[1:0], 4'h9}, rd);
    end
    for (int i = 0; i < 7; i++) begin
      e = runs[i];
      reg_wr(IPB_CFG_ADDR, e[31:24]);
      #1 chk("sync oe", {7'h00, e[27]}, {7'h00, tx_frame_sync_pin.oe});
      if (i == 0) begin
        @(posedge clk) tx_byte <= 8'h3C;
        tx_valid <= 1'b1;
        @(posedge clk) tx_valid <= 1'b0;
        #1 chk("tx ready", 8'h00, {7'h00, tx_ready});
      end
      tx_clock_pin_en <= e[16];
      run <= 1'b1;
      repeat (2) @(posedge clk);
      for (int k = 0; k < 4000 && done !== 1'b1; k++)
        @(posedge clk);
      chk("driven bits", e[15:8], drv_cnt);
      chk("first driven", e[7:0], first_cnt);
      chk("tx sync", {7'h00, e[27] & e[16]}, sync_cnt);
      run <= 1'b0;
      if (i == 0) begin
        chk("tx byte", 8'h3C, cap);
        chk("tx ready", 8'h01, {7'h00, tx_ready});
        repeat (8) @(posedge clk);
        chk("drops", 8'h04, drops);
        for (int k = 0; k < 4; k++) begin
          chk("rx byte", 8'hA4, rx_byte);
          @(posedge clk) rx_ready <= 1'b1;
          @(posedge clk) rx_ready <= 1'b0;
          #1;
        end
        chk("rx empty", 8'h00, {7'h00, rx_valid});
        rx_ready <= 1'b1;
      end
    end
    complete_run();
  end
endmodule
